/* File: rtl/bfp_pkg.sv */
package bfp_pkg;
  // stream framing constants
  localparam logic [31:0] BFP_SYNC_WORD = 32'hFFFFBDB3;
  localparam logic [15:0] BFP_SYNC_HIGH = 16'hFFFF;
  localparam logic [31:0] BFP_ONES_WORD = 32'hFFFFFFFF;
  localparam logic [7:0] BFP_ONES_BYTE = 8'hFF;
  localparam logic [7:0] BFP_COMMENT_END = 8'h00;
  localparam logic [31:0] BFP_SIGNATURE_DEF = 32'h5A5A1234; // arbitrary value
  localparam logic [31:0] BFP_DEVICE_ID_DEF = 32'h0000ABCD; // arbitrary value
  // command opcodes
  localparam logic [7:0] BFP_OP_CRC_CLEAR = 8'h3B;
  localparam logic [7:0] BFP_OP_ID_CHECK = 8'hE2;
  localparam logic [7:0] BFP_OP_CTRL0 = 8'h22;
  localparam logic [7:0] BFP_OP_CTRL1 = 8'h23;
  localparam logic [7:0] BFP_OP_ADDR_SET = 8'hB4;
  localparam logic [7:0] BFP_OP_AUTOINC = 8'h82;
  // command word field positions
  localparam int BFP_OP_MSB = 31;
  localparam int BFP_OP_LSB = 24;
  localparam int BFP_CRCFLAG_BIT = 23;
  localparam int BFP_ATEND_BIT = 22;
  localparam int BFP_DUMDEF_BIT = 20;
  localparam int BFP_DUMCNT_MSB = 19;
  localparam int BFP_DUMCNT_LSB = 16;
  localparam int BFP_FCNT_MSB = 15;
  // frame layout
  localparam logic [15:0] BFP_MIB_FRAMES = 16'h0020;
  localparam int BFP_FRAME_BYTES_DEF = 9;
  localparam logic [15:0] BFP_CRC_POLY = 16'h8005;
  localparam logic [15:0] BFP_CRC_INIT = 16'h0000;

  typedef enum logic [2:0] {BFP_ERR_NONE, BFP_ERR_SIG, BFP_ERR_ID, BFP_ERR_CRC, BFP_ERR_CMD} bfp_err_e;

  typedef struct packed {
    logic [31:0] ctrl0;
    logic [31:0] ctrl1;
    logic [15:0] frame_addr;
  } bfp_cfg_s;

  typedef struct packed {
    logic busy;
    logic error;
    logic mib_done;
    bfp_err_e code;
  } bfp_status_s;
endpackage

/* File: rtl/bfp_crc16.sv */
`timescale 1ns/1ps
// byte-wide crc16 update, msb first
module bfp_crc16
  import bfp_pkg::*;
(
  input wire logic [15:0] crc_in, // running value
  input wire logic [7:0] data_in, // next byte
  output logic [15:0] crc_out // updated value
);
  // one shift per data bit
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ BFP_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule

/* File: rtl/bfp_parser.sv */
`timescale 1ns/1ps
module bfp_parser
  import bfp_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = BFP_SIGNATURE_DEF, // expected signature
  parameter logic [31:0] DEVICE_ID = BFP_DEVICE_ID_DEF, // own identifier
  parameter int FRAME_BYTES = BFP_FRAME_BYTES_DEF // data bytes per frame
)(
  input wire logic clk, // 20 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // restart parse
  input wire logic in_valid, // stream byte present
  input wire logic [7:0] in_data, // stream byte
  output logic in_ready, // byte accepted when valid
  output logic wr_valid, // frame byte write strobe
  output logic [7:0] wr_data, // frame byte
  output logic [15:0] wr_addr, // frame address of write
  output logic frame_ok, // pulse: frame crc matched, or frame accepted unchecked when at-end flag is set
  output bfp_cfg_s cfg, // loaded registers
  output bfp_status_s status // parse status
);
  typedef enum logic [3:0] {
    S_SIG, S_COMMENT, S_SYNC, S_CMD, S_OPER, S_FRAME, S_CRC, S_GAP, S_DONE, S_ERR
  } bfp_state_e;

  bfp_state_e state_r;
  logic [31:0] shift_r;
  logic [2:0] bcnt_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [31:0] cmd_r;
  logic [15:0] crcw_r;
  logic [15:0] crc_src;
  logic [1:0] skip_r;
  logic [15:0] frames_left_r;
  logic [3:0] gap_r;
  logic [15:0] dcnt_r;
  logic crc_on_r;
  logic [31:0] word;
  logic take;
  logic word_end;
  logic [15:0] crc_rx;

  bfp_crc16 u_crc (
    .crc_in(crc_src),
    .data_in(in_data),
    .crc_out(crc_nxt)
  );

  assign take = in_valid & in_ready;
  assign word = {shift_r[23:0], in_data};
  assign word_end = (bcnt_r == 3'h3);
  // command words run on a side crc, committed only once known not to be no-ops
  assign crc_src = (state_r == S_CMD && bcnt_r != 3'h0) ? crcw_r : crc_r;
  // received crc, bit reversed on the wire
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      crc_rx[i] = word[15 - i];
    end
  end

  // byte ready unless stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (state_r != S_DONE) && (state_r != S_ERR);
    end
  end

  // byte assembly into words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 32'h0000_0000;
      bcnt_r <= 3'h0;
    end else if (start) begin
      bcnt_r <= 3'h0;
    end else if (take) begin
      shift_r <= word;
      if (state_r == S_COMMENT || state_r == S_SYNC || state_r == S_FRAME || state_r == S_GAP) begin
        bcnt_r <= 3'h0;
      end else if (state_r == S_CRC) begin
        bcnt_r <= (bcnt_r == 3'h1) ? 3'h0 : bcnt_r + 3'h1;
      end else begin
        bcnt_r <= word_end ? 3'h0 : bcnt_r + 3'h1;
      end
    end
  end

  // main parse sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_SIG;
      cmd_r <= 32'h0000_0000;
      crcw_r <= BFP_CRC_INIT;
      skip_r <= 2'h0;
      frames_left_r <= 16'h0000;
      gap_r <= 4'h0;
      dcnt_r <= 16'h0000;
      crc_r <= BFP_CRC_INIT;
      crc_on_r <= 1'b0;
      cfg <= '0;
      status <= '{busy: 1'b0, error: 1'b0, mib_done: 1'b0, code: BFP_ERR_NONE};
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      wr_addr <= 16'h0000;
      frame_ok <= 1'b0;
    end else if (start) begin
      state_r <= S_SIG;
      crc_r <= BFP_CRC_INIT;
      crc_on_r <= 1'b0;
      status <= '{busy: 1'b1, error: 1'b0, mib_done: 1'b0, code: BFP_ERR_NONE};
      skip_r <= 2'h0;
      wr_valid <= 1'b0;
      frame_ok <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      frame_ok <= 1'b0;
      // an aborted parse is no longer busy, byte or not
      if (state_r == S_ERR) begin
        status.busy <= 1'b0;
      end
      if (take) begin
        // crc runs only inside included regions; command words commit whole
        if (crc_on_r && state_r != S_CRC && state_r != S_SYNC && state_r != S_CMD) begin
          crc_r <= crc_nxt;
        end
        unique case (state_r)
          S_SIG: begin
            status.busy <= 1'b1;
            if (word_end) begin
              if (word == SIGNATURE) begin
                state_r <= S_COMMENT;
              end else begin
                state_r <= S_ERR;
                status.error <= 1'b1;
                status.code <= BFP_ERR_SIG;
              end
            end
          end
          S_COMMENT: begin
            if (in_data == BFP_COMMENT_END) begin
              state_r <= S_SYNC;
            end
          end
          S_SYNC: begin
            // sliding match: leading ones then pattern
            if (word == BFP_SYNC_WORD && word[31:16] == BFP_SYNC_HIGH) begin
              state_r <= S_CMD;
            end
          end
          S_CMD: begin
            crcw_r <= crc_nxt;
            if (word_end) begin
              cmd_r <= word;
              if (word == BFP_ONES_WORD) begin
                // all-ones word leaves crc alone; the second one after a clear is the id slot
                if (skip_r == 2'h1) begin
                  crc_on_r <= 1'b1;
                end
                if (skip_r != 2'h0) begin
                  skip_r <= skip_r - 2'h1;
                end
              end else begin
                skip_r <= 2'h0;
                if (crc_on_r) begin
                  crc_r <= crc_nxt;
                end
                unique case (word[BFP_OP_MSB:BFP_OP_LSB])
                  BFP_OP_CRC_CLEAR: begin
                    crc_r <= BFP_CRC_INIT;
                    crc_on_r <= 1'b0;
                    skip_r <= 2'h2;
                  end
                  BFP_OP_ID_CHECK, BFP_OP_CTRL0, BFP_OP_CTRL1, BFP_OP_ADDR_SET: begin
                    if (word[BFP_OP_MSB:BFP_OP_LSB] == BFP_OP_ID_CHECK) begin
                      crc_r <= crc_nxt;
                      crc_on_r <= 1'b1;
                    end
                    state_r <= S_OPER;
                  end
                  BFP_OP_AUTOINC: begin
                    if (word[BFP_FCNT_MSB:0] != BFP_MIB_FRAMES) begin
                      state_r <= S_ERR;
                      status.error <= 1'b1;
                      status.code <= BFP_ERR_CMD;
                    end else begin
                      frames_left_r <= word[BFP_FCNT_MSB:0];
                      gap_r <= word[BFP_DUMDEF_BIT] ? word[BFP_DUMCNT_MSB:BFP_DUMCNT_LSB] : 4'h1;
                      dcnt_r <= 16'h0000;
                      state_r <= S_FRAME;
                    end
                  end
                  default: begin
                    state_r <= S_ERR;
                    status.error <= 1'b1;
                    status.code <= BFP_ERR_CMD;
                  end
                endcase
              end
            end
          end
          S_OPER: begin
            if (word_end) begin
              state_r <= S_CMD;
              unique case (cmd_r[BFP_OP_MSB:BFP_OP_LSB])
                BFP_OP_ID_CHECK: begin
                  if (word != DEVICE_ID) begin
                    state_r <= S_ERR;
                    status.error <= 1'b1;
                    status.code <= BFP_ERR_ID;
                  end
                end
                BFP_OP_CTRL0: cfg.ctrl0 <= word;
                BFP_OP_CTRL1: cfg.ctrl1 <= word;
                BFP_OP_ADDR_SET: cfg.frame_addr <= word[BFP_FCNT_MSB:0];
                default: state_r <= S_CMD;
              endcase
            end
          end
          S_FRAME: begin
            wr_valid <= 1'b1;
            wr_data <= in_data;
            wr_addr <= cfg.frame_addr;
            if (dcnt_r == 16'(FRAME_BYTES - 1)) begin
              dcnt_r <= 16'h0000;
              state_r <= S_CRC;
            end else begin
              dcnt_r <= dcnt_r + 16'h0001;
            end
          end
          S_CRC: begin
            if (bcnt_r == 3'h1) begin
              // compare per frame when at-end flag is clear
              if (!cmd_r[BFP_ATEND_BIT] && crc_rx != crc_r) begin
                state_r <= S_ERR;
                status.error <= 1'b1;
                status.code <= BFP_ERR_CRC;
              end else begin
                frame_ok <= 1'b1;
                cfg.frame_addr <= cfg.frame_addr + 16'h0001;
                frames_left_r <= frames_left_r - 16'h0001;
                if (frames_left_r == 16'h0001) begin
                  state_r <= S_DONE;
                  status.busy <= 1'b0;
                  status.mib_done <= 1'b1;
                end else begin
                  state_r <= S_GAP;
                end
              end
            end
          end
          S_GAP: begin
            // gap byte restarts crc for next frame
            crc_r <= BFP_CRC_INIT;
            if (in_data != BFP_ONES_BYTE) begin
              state_r <= S_ERR;
              status.error <= 1'b1;
              status.code <= BFP_ERR_CMD;
            end else if (dcnt_r[3:0] == gap_r - 4'h1) begin
              dcnt_r <= 16'h0000;
              state_r <= S_FRAME;
            end else begin
              dcnt_r <= dcnt_r + 16'h0001;
            end
          end
          S_DONE: state_r <= S_DONE;
          S_ERR: state_r <= S_ERR;
        endcase
      end
    end
  end
endmodule

/* File: test/bfp_parser_properties.sv */
`timescale 1ns/1ps
// port-level checks of the frame parser
module bfp_parser_checker
  import bfp_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = BFP_SIGNATURE_DEF, // expected signature
  parameter logic [31:0] DEVICE_ID = BFP_DEVICE_ID_DEF, // own identifier
  parameter int FRAME_BYTES = BFP_FRAME_BYTES_DEF // data bytes per frame
)(
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // restart parse
  input wire logic in_valid, // byte present
  input wire logic [7:0] in_data, // stream byte
  input wire logic in_ready, // byte accepted
  input wire logic wr_valid, // frame byte strobe
  input wire logic [7:0] wr_data, // frame byte
  input wire logic [15:0] wr_addr, // frame address
  input wire logic frame_ok, // good frame pulse
  input wire bfp_cfg_s cfg, // loaded registers
  input wire bfp_status_s status // parse status
);
  logic [5:0] ok_cnt; // good frames since start
  // count good frames since the last start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_cnt <= 6'h00;
    end else if (start) begin
      ok_cnt <= 6'h00;
    end else if (frame_ok) begin
      ok_cnt <= ok_cnt + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ERR_STOPS_READY: assert property (status.error && !start |=> !in_ready)
    else $error("byte accepted after error");
  AST_ERR_CODE: assert property (status.error |-> status.code != BFP_ERR_NONE)
    else $error("error without code");
  AST_ERR_NO_OK: assert property ($rose(status.error) |-> !frame_ok)
    else $error("good frame flagged with error");
  AST_OK_PULSE: assert property (frame_ok |=> !frame_ok)
    else $error("frame good longer than one cycle");
  AST_ADDR_ADV: assert property (frame_ok |-> ##[0:1] (cfg.frame_addr == wr_addr + 16'h0001))
    else $error("frame address did not advance");
  AST_OUT_NEEDS_BYTE: assert property (wr_valid || frame_ok |-> $past(in_valid && in_ready))
    else $error("output without accepted byte");
  AST_WR_DATA: assert property (wr_valid |-> wr_data == $past(in_data))
    else $error("written byte differs from stream");
  AST_DONE_COUNT: assert property (status.mib_done |-> ##[0:2] (ok_cnt == BFP_MIB_FRAMES[5:0]))
    else $error("done without thirty-two frames");
  AST_CFG_HOLD: assert property (!in_ready && !start |=> $stable(cfg))
    else $error("registers changed while idle");
  AST_ERR_NOT_BUSY: assert property (status.error && !start |=> !status.busy)
    else $error("still busy after error");
  COV_OK: cover property (frame_ok);
  COV_DONE: cover property ($rose(status.mib_done));
  COV_ERR: cover property ($rose(status.error));
endmodule

bind bfp_parser bfp_parser_checker #(.SIGNATURE(SIGNATURE), .DEVICE_ID(DEVICE_ID), .FRAME_BYTES(FRAME_BYTES))
  u_chk (.clk, .rst_n, .start, .in_valid, .in_data, .in_ready, .wr_valid, .wr_data, .wr_addr, .frame_ok,
  .cfg, .status);

/* File: test/bfp_source.sv */
`timescale 1ns/1ps
// byte source standing in for the configuration host
module bfp_source (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic slow, // random stalls when high
  input wire logic in_ready, // parser accepts
  output logic in_valid, // byte offered
  output logic [7:0] in_data // offered byte
);
  logic [7:0] q[$]; // bytes still to send
  logic [31:0] lfsr_r; // stall pattern
  // offer bytes in order, each held until taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
      in_data <= 8'h00;
      lfsr_r <= 32'h7FB1152B;
    end else begin
      lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      if (in_valid && in_ready) begin
        void'(q.pop_front());
      end
      if (in_valid && !in_ready) begin
        in_valid <= 1'b1;
      end else if (q.size() > 0 && !(slow && lfsr_r[0])) begin
        in_valid <= 1'b1;
        in_data <= q[0];
      end else begin
        in_valid <= 1'b0;
        in_data <= ~in_data; // idle bus inverts the data bits every cycle
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
// self-checking bench for the frame parser
module tb_top
  import bfp_pkg::*;
;
  localparam int FB = 3; // shortened frame
  localparam logic [15:0] BASE = 16'h0100; // first frame address
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic in_valid, in_ready, wr_valid, frame_ok;
  logic [7:0] in_data, wr_data;
  logic [15:0] wr_addr, crc;
  bfp_cfg_s cfg;
  bfp_status_s status;
  logic [31:0] rnd = 32'h7FB1152B;
  int bad_count = 0;
  int checks = 0;
  int n_ok = 0;
  int n_wr = 0;
  int cycles = 0;
  logic [7:0] exp_q[$]; // frame bytes still expected on the write port
  int exp_ok[6] = '{32, 32, 0, 3, 0, 0};
  int exp_fr[6] = '{32, 32, 0, 4, 0, 0};
  bfp_err_e exp_code[6] = '{BFP_ERR_NONE, BFP_ERR_NONE, BFP_ERR_ID, BFP_ERR_CRC, BFP_ERR_CMD, BFP_ERR_SIG};

  always #25 clk = ~clk;

  bfp_source src (.clk, .rst_n, .slow, .in_ready, .in_valid, .in_data);
  bfp_parser #(.FRAME_BYTES(FB)) dut (.clk, .rst_n, .start, .in_valid, .in_data, .in_ready, .wr_valid,
    .wr_data, .wr_addr, .frame_ok, .cfg, .status);

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // queue a byte, folding it into the model crc when asked
  task automatic put8(input logic [7:0] b, input bit acc);
    src.q.push_back(b);
    for (int i = 7; i >= 0 && acc; i--) begin
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? BFP_CRC_POLY : 16'h0000);
    end
  endtask

  task automatic put32(input logic [31:0] w, input bit acc);
    for (int k = 3; k >= 0; k--) begin
      put8(w[8*k +: 8], acc);
    end
  endtask

  // watch writes and good frames, cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (wr_valid === 1'b1) begin
      check(32'(wr_addr), 32'(BASE + 16'(n_wr / FB)));
      check(32'(wr_data), 32'(exp_q[0]));
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
      n_wr++;
    end
    if (frame_ok === 1'b1) begin
      n_ok++;
    end
    if (cycles > 8000) begin
      bad_count++;
      give_verdict();
    end
  end

  // one stream; mode 0 good, 1 no-op id, 2 bad id, 3 bad crc, 4 bad count, 5 bad signature
  task automatic run(input int mode);
    logic [15:0] r;
    bit cfgd;
    cfgd = mode inside {0, 1, 3, 4};
    rst_n <= 1'b0;
    src.q.delete();
    exp_q.delete();
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    slow <= mode[0];
    n_ok = 0;
    n_wr = 0;
    repeat (2) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    put32(mode == 5 ? ~BFP_SIGNATURE_DEF : BFP_SIGNATURE_DEF, 0);
    put8(8'h41, 0);
    put8(BFP_COMMENT_END, 0);
    put32(BFP_SYNC_WORD, 0);
    put32(BFP_ONES_WORD, 0);
    put32({BFP_OP_CRC_CLEAR, 24'h000000}, 0);
    put32(BFP_ONES_WORD, 0);
    crc = BFP_CRC_INIT;
    if (mode == 1) begin
      put32(BFP_ONES_WORD, 0);
    end else begin
      put32({BFP_OP_ID_CHECK, 24'h000000}, 1);
      put32(mode == 2 ? ~BFP_DEVICE_ID_DEF : BFP_DEVICE_ID_DEF, 1);
    end
    put32({BFP_OP_CTRL0, 24'h000000}, 1);
    put32(32'h00123456, 1);
    put32(BFP_ONES_WORD, 0);
    put32({BFP_OP_CTRL1, 24'h000000}, 1);
    put32(32'h89ABCDEF, 1);
    put32({BFP_OP_ADDR_SET, 24'h000000}, 1);
    put32({16'h0000, BASE}, 1);
    put32({BFP_OP_AUTOINC, 8'h91, mode == 4 ? 16'h001F : BFP_MIB_FRAMES}, 1);
    for (int f = 0; f < 32; f++) begin
      if (f > 0) begin
        put8(BFP_ONES_BYTE, 0);
        crc = BFP_CRC_INIT;
      end
      for (int j = 0; j < FB; j++) begin
        rnd = lfsr(rnd);
        put8(rnd[7:0], 1);
        exp_q.push_back(rnd[7:0]);
      end
      r = {<<{crc}};
      if (mode == 3 && f == 3) begin
        r = ~r;
      end
      put8(r[15:8], 0);
      put8(r[7:0], 0);
    end
    for (int j = 0; j < 3000 && status.mib_done !== 1'b1 && status.error !== 1'b1; j++) begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    check(32'(status.code), 32'(exp_code[mode]));
    check(32'(status.error), 32'(mode > 1));
    check(32'(status.mib_done), 32'(mode < 2));
    check(32'(in_ready), 32'h0);
    check(32'(status.busy), 32'h0);
    check(n_ok, exp_ok[mode]);
    check(n_wr, exp_fr[mode] * FB);
    check(cfg.ctrl0, cfgd ? 32'h00123456 : 32'h0);
    check(cfg.ctrl1, cfgd ? 32'h89ABCDEF : 32'h0);
    check(32'(cfg.frame_addr), cfgd ? 32'(BASE) + exp_ok[mode] : 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    for (int m = 0; m < 6; m++) begin
      run(m);
    end
    give_verdict();
  end
endmodule
